// File: include/iusc_defs.svh
// Operation
// - The four registers sit at configuration indexes 4CH, 4DH, 4EH and 4FH, 8-bit access.
// - Routing bit 7 clear enables IDE interrupt 1 routing; set disables it.
// - Level codes map to IRQ3-7, IRQ9-12, IRQ14, IRQ15; other codes are reserved.
// - Arbiter bit 7 clear sends every internal master through the primary pair.
// - Arbiter bit set moves the USB master to the secondary pair only.
// - With the internal arbiter strapped, the arbiter bit has no effect.
// - Flush mode 00 performs the flush handshake over the handshake pin.
// - Flush mode 01 uses the pin handshake and masks IRQ8 internally.
// - Flush mode 10 acknowledges internally and leaves the pin undriven.
// - Flush mode 11 acknowledges internally, masks IRQ8, drives IRQ8 on the pin.
// - Decode bit 4 clear uses low 16 address bits; set uses all 32.
// - ROM bit 3 clear decodes 512KB ROM space; set decodes 1MB.
// - USB interface bit 0 clear disables the interface; set enables it.
// - USB control bits 7:6 select test mode, bit 5 enables it; reset zero.
// - USB control bit 4 enables the IRQ1 keyboard-emulation interrupt.
// - USB control bit 3 enables the IRQ12 interrupt.
// - USB control bit 2 enables the fast address-line-20 gate.
// - USB control bit 1 enables system management interrupt generation.
// - Second USB control bits 5:4 map the USB interrupt to INTA-INTD.
`ifndef IUSC_DEFS_SVH
`define IUSC_DEFS_SVH

`define IUSC_IDX_IDE_IRQ1    8'h4C
`define IUSC_IDX_SA_USB_CTL  8'h4D
`define IUSC_IDX_USB_CTL1    8'h4E
`define IUSC_IDX_USB_CTL2    8'h4F

`define IUSC_RST_IDE_IRQ1    8'h00
`define IUSC_RST_SA_USB_CTL  8'h00
`define IUSC_RST_USB_CTL1    8'h00
`define IUSC_RST_USB_CTL2    8'h00

`define IUSC_MSK_IDE_IRQ1    8'h8F
`define IUSC_MSK_SA_USB_CTL  8'hF9
`define IUSC_MSK_USB_CTL1    8'hFE
`define IUSC_MSK_USB_CTL2    8'hF0

`define IUSC_B_ROUTE_DIS     7
`define IUSC_B_ARB_SEC       7
`define IUSC_B_FLUSH_HI      6
`define IUSC_B_FLUSH_LO      5
`define IUSC_B_IDE_FULL      4
`define IUSC_B_ROM_1MB       3
`define IUSC_B_USB_EN        0
`define IUSC_B_TEST_HI       7
`define IUSC_B_TEST_LO       6
`define IUSC_B_TEST_EN       5
`define IUSC_B_IRQ1_EN       4
`define IUSC_B_IRQ12_EN      3
`define IUSC_B_A20_EN        2
`define IUSC_B_SMI_EN        1
`define IUSC_B_SMIACT_EN     7
`define IUSC_B_PWREN_EN      6
`define IUSC_B_MAP_HI        5
`define IUSC_B_MAP_LO        4

`define IUSC_FLUSH_PIN       2'b00
`define IUSC_FLUSH_PIN_MASK  2'b01
`define IUSC_FLUSH_AUTO      2'b10
`define IUSC_FLUSH_AUTO_IRQ8 2'b11

`define IUSC_ACK_LAT         1

`endif

// File: include/iusc_pkg.sv
package iusc_pkg;

  typedef enum logic [1:0] {
    IUSC_FL_IDLE,
    IUSC_FL_DRIVE,
    IUSC_FL_WAIT,
    IUSC_FL_HOLD
  } iusc_flush_e;

  typedef struct packed {
    iusc_flush_e st;
    logic        ack;
  } iusc_flush_s;

  typedef struct packed {
    logic [7:0] route;
    logic [7:0] ctl;
    logic [7:0] usb1;
    logic [7:0] usb2;
    logic [7:0] rdata;
    logic       ack;
    logic       strap_int;
    logic       strap_seen;
  } iusc_state_s;

endpackage

// File: hw/iusc_flush.sv
`timescale 1ns/10ps
`include "iusc_defs.svh"

module iusc_flush (
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic [1:0] i_mode,
  input  wire logic       i_flush_req,
  input  wire logic       i_irq8,
  input  wire logic       i_fhs_in,
  output logic            o_fhs_out,
  output logic            o_fhs_oe,
  output logic            o_flush_ack,
  output logic            o_irq8_pic
);

  iusc_pkg::iusc_flush_s s_q;
  iusc_pkg::iusc_flush_s s_d;

  logic auto_ack;
  assign auto_ack = i_mode[1];

  always_comb begin
    s_d     = s_q;
    s_d.ack = 1'b0;
    case (s_q.st)
      iusc_pkg::IUSC_FL_IDLE: begin
        if (i_flush_req) begin
          if (auto_ack) begin
            s_d.st  = iusc_pkg::IUSC_FL_HOLD;
            s_d.ack = 1'b1;
          end else begin
            s_d.st = iusc_pkg::IUSC_FL_DRIVE;
          end
        end
      end
      iusc_pkg::IUSC_FL_DRIVE: begin
        s_d.st = i_flush_req ? iusc_pkg::IUSC_FL_WAIT : iusc_pkg::IUSC_FL_IDLE;
      end
      iusc_pkg::IUSC_FL_WAIT: begin
        // Mode switched to automatic mid handshake: finish it internally
        if (!i_flush_req) begin
          s_d.st = iusc_pkg::IUSC_FL_IDLE;
        end else if (i_fhs_in || auto_ack) begin
          s_d.st  = iusc_pkg::IUSC_FL_HOLD;
          s_d.ack = 1'b1;
        end
      end
      default: begin
        if (!i_flush_req) begin
          s_d.st = iusc_pkg::IUSC_FL_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      s_q <= '{st: iusc_pkg::IUSC_FL_IDLE, ack: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Request phase drives the pin for one cycle, then releases it for the answer
  assign o_fhs_oe    = (i_mode == `IUSC_FLUSH_AUTO_IRQ8) ||
                       (!auto_ack && s_q.st == iusc_pkg::IUSC_FL_DRIVE);
  assign o_fhs_out   = (i_mode == `IUSC_FLUSH_AUTO_IRQ8) ? i_irq8 : 1'b1;
  assign o_flush_ack = s_q.ack;
  assign o_irq8_pic  = i_irq8 && !i_mode[0];

  chk_auto_ack_fast: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (s_q.st == iusc_pkg::IUSC_FL_IDLE && i_flush_req && i_mode == `IUSC_FLUSH_AUTO)
    |=> o_flush_ack && !o_fhs_oe)
    else $error("automatic flush ack late or pin driven");
  chk_pin_irq8: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_mode == `IUSC_FLUSH_AUTO_IRQ8) |-> o_fhs_oe && (o_fhs_out == i_irq8))
    else $error("irq8 not driven on handshake pin");
  chk_pin_wait_ack: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (s_q.st == iusc_pkg::IUSC_FL_WAIT && i_flush_req && i_fhs_in && i_mode == `IUSC_FLUSH_PIN)
    |=> o_flush_ack ##1 !o_flush_ack)
    else $error("pin handshake ack missing or held");
  cov_pin_flush: cover property (@(posedge i_clk) disable iff (!i_nrst)
    (i_mode == `IUSC_FLUSH_PIN) && (s_q.st == iusc_pkg::IUSC_FL_WAIT) ##1 o_flush_ack);

endmodule

// File: hw/iusc_top.sv
`timescale 1ns/10ps
`include "iusc_defs.svh"

module iusc_top #(
  parameter int IDX_W  = 8,
  parameter int DATA_W = 8
) (
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  input  wire logic [IDX_W-1:0]  i_cfg_idx,
  input  wire logic              i_cfg_wr,
  input  wire logic              i_cfg_rd,
  input  wire logic [DATA_W-1:0] i_cfg_wdata,
  output logic [DATA_W-1:0]      o_cfg_rdata,
  output logic                   o_cfg_ack,
  output logic                   o_cfg_hit,
  input  wire logic              i_ide_irq1,
  output logic [15:0]            o_ide_irq1_route,
  output logic                   o_route_valid,
  input  wire logic              i_int_arb_strap,
  input  wire logic              i_usb_req,
  input  wire logic              i_oth_req,
  input  wire logic              i_pgnt,
  input  wire logic              i_sgnt,
  output logic                   o_primary_bus_request,
  output logic                   o_secondary_bus_request,
  output logic                   o_usb_gnt,
  output logic                   o_oth_gnt,
  input  wire logic              i_flush_req,
  input  wire logic              i_irq8,
  input  wire logic              i_flush_handshake_signal_in,
  output logic                   o_flush_handshake_signal_out,
  output logic                   o_flush_handshake_signal_oe,
  output logic                   o_flush_ack,
  output logic                   o_irq8_pic,
  input  wire logic [31:0]       i_io_addr,
  output logic                   o_ide_addr_ok,
  output logic                   o_ide_full_decode,
  input  wire logic [31:0]       i_mem_addr,
  output logic                   o_rom_hit,
  output logic                   o_rom_1mb,
  output logic                   o_usb_enable,
  output logic [1:0]             o_usb_test_sel,
  output logic                   o_usb_test_en,
  input  wire logic              i_usb_irq1,
  input  wire logic              i_usb_irq12,
  input  wire logic              i_usb_smi,
  input  wire logic              i_usb_a20,
  input  wire logic              i_usb_int,
  output logic                   o_usb_irq1,
  output logic                   o_usb_irq12,
  output logic                   o_fast_addr20_gate,
  output logic                   o_system_mgmt_interrupt,
  output logic                   o_usb_smiact_en,
  output logic                   o_usb_pwren_en,
  output logic [3:0]             o_usb_pci_int
);

  generate
    if (IDX_W != 8 || DATA_W != 8) begin : g_bad_width
      $error("iusc_top serves 8-bit indexes and 8-bit data only");
    end
  endgenerate

  // Shared by the router and the o_route_valid flag
  function automatic logic [15:0] route_decode(input logic [3:0] code);
    logic [15:0] hot;
    hot = 16'h0000;
    case (code)
      4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
      4'h9, 4'hA, 4'hB, 4'hC,
      4'hE, 4'hF: hot[code] = 1'b1;
      default:    hot = 16'h0000;
    endcase
    return hot;
  endfunction

  iusc_pkg::iusc_state_s s_q;
  iusc_pkg::iusc_state_s s_d;

  logic       acc;
  logic [7:0] wdata;
  logic       use_sec;
  logic [1:0] flush_mode;

  assign acc   = i_cfg_wr || i_cfg_rd;
  assign wdata = i_cfg_wdata;

  always_comb begin
    s_d       = s_q;
    s_d.ack   = acc;
    s_d.rdata = 8'h00;
    if (!s_q.strap_seen) begin
      // Strap is caught on the first edge after reset is released
      s_d.strap_int  = i_int_arb_strap;
      s_d.strap_seen = 1'b1;
    end
    if (i_cfg_wr) begin
      if (i_cfg_idx == `IUSC_IDX_IDE_IRQ1) begin
        s_d.route = wdata & `IUSC_MSK_IDE_IRQ1;
      end else if (i_cfg_idx == `IUSC_IDX_SA_USB_CTL) begin
        s_d.ctl = wdata & `IUSC_MSK_SA_USB_CTL;
      end else if (i_cfg_idx == `IUSC_IDX_USB_CTL1) begin
        s_d.usb1 = wdata & `IUSC_MSK_USB_CTL1;
      end else if (i_cfg_idx == `IUSC_IDX_USB_CTL2) begin
        s_d.usb2 = wdata & `IUSC_MSK_USB_CTL2;
      end
    end else if (i_cfg_rd) begin
      if (i_cfg_idx == `IUSC_IDX_IDE_IRQ1) begin
        s_d.rdata = s_q.route;
      end else if (i_cfg_idx == `IUSC_IDX_SA_USB_CTL) begin
        s_d.rdata = s_q.ctl;
      end else if (i_cfg_idx == `IUSC_IDX_USB_CTL1) begin
        s_d.rdata = s_q.usb1;
      end else if (i_cfg_idx == `IUSC_IDX_USB_CTL2) begin
        s_d.rdata = s_q.usb2;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      s_q <= '{route:      `IUSC_RST_IDE_IRQ1,
               ctl:        `IUSC_RST_SA_USB_CTL,
               usb1:       `IUSC_RST_USB_CTL1,
               usb2:       `IUSC_RST_USB_CTL2,
               rdata:      8'h00,
               ack:        1'b0,
               strap_int:  1'b0,
               strap_seen: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Indexes outside the bank are left for the neighbouring registers to claim
  assign o_cfg_hit   = (i_cfg_idx == `IUSC_IDX_IDE_IRQ1)   ||
                       (i_cfg_idx == `IUSC_IDX_SA_USB_CTL) ||
                       (i_cfg_idx == `IUSC_IDX_USB_CTL1)   ||
                       (i_cfg_idx == `IUSC_IDX_USB_CTL2);
  assign o_cfg_rdata = s_q.rdata;
  assign o_cfg_ack   = s_q.ack;

  // IDE interrupt 1 router; reserved codes route nowhere
  logic [15:0] route_hot;
  assign route_hot     = route_decode(s_q.route[3:0]);
  assign o_route_valid = !s_q.route[`IUSC_B_ROUTE_DIS] && (route_hot != 16'h0000);

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_route
      assign o_ide_irq1_route[gi] = route_hot[gi] && i_ide_irq1 &&
                                    !s_q.route[`IUSC_B_ROUTE_DIS];
    end
  endgenerate

  // External arbitration pairs; the strap overrides the protocol bit
  assign use_sec = s_q.ctl[`IUSC_B_ARB_SEC] && !s_q.strap_int;
  assign o_primary_bus_request   = i_oth_req || (i_usb_req && !use_sec);
  assign o_secondary_bus_request = i_usb_req && use_sec;
  assign o_oth_gnt = i_pgnt && i_oth_req;
  // Sharing the primary pair, other masters win; USB waits for the next grant
  assign o_usb_gnt = use_sec ? (i_sgnt && i_usb_req)
                             : (i_pgnt && i_usb_req && !i_oth_req);

  assign flush_mode = s_q.ctl[`IUSC_B_FLUSH_HI:`IUSC_B_FLUSH_LO];

  iusc_flush u_flush (
    .i_clk       (i_clk),
    .i_nrst      (i_nrst),
    .i_mode      (flush_mode),
    .i_flush_req (i_flush_req),
    .i_irq8      (i_irq8),
    .i_fhs_in    (i_flush_handshake_signal_in),
    .o_fhs_out   (o_flush_handshake_signal_out),
    .o_fhs_oe    (o_flush_handshake_signal_oe),
    .o_flush_ack (o_flush_ack),
    .o_irq8_pic  (o_irq8_pic)
  );

  // Address qualifiers for the IDE and ROM decoders
  assign o_ide_full_decode = s_q.ctl[`IUSC_B_IDE_FULL];
  assign o_ide_addr_ok     = !s_q.ctl[`IUSC_B_IDE_FULL] ||
                             (i_io_addr[31:16] == 16'h0000);
  assign o_rom_1mb         = s_q.ctl[`IUSC_B_ROM_1MB];
  assign o_rom_hit         = s_q.ctl[`IUSC_B_ROM_1MB] ? (i_mem_addr[31:20] == 12'hFFF)
                                                      : (i_mem_addr[31:19] == 13'h1FFF);
  assign o_usb_enable      = s_q.ctl[`IUSC_B_USB_EN];

  // USB host controller enables
  assign o_usb_test_sel          = s_q.usb1[`IUSC_B_TEST_HI:`IUSC_B_TEST_LO];
  assign o_usb_test_en           = s_q.usb1[`IUSC_B_TEST_EN];
  assign o_usb_irq1              = i_usb_irq1 && s_q.usb1[`IUSC_B_IRQ1_EN];
  assign o_usb_irq12             = i_usb_irq12 && s_q.usb1[`IUSC_B_IRQ12_EN];
  assign o_fast_addr20_gate      = i_usb_a20 && s_q.usb1[`IUSC_B_A20_EN];
  assign o_system_mgmt_interrupt = i_usb_smi && s_q.usb1[`IUSC_B_SMI_EN];
  assign o_usb_smiact_en         = s_q.usb2[`IUSC_B_SMIACT_EN];
  assign o_usb_pwren_en          = s_q.usb2[`IUSC_B_PWREN_EN];

  generate
    for (gi = 0; gi < 4; gi++) begin : g_pci_int
      assign o_usb_pci_int[gi] = i_usb_int &&
        (s_q.usb2[`IUSC_B_MAP_HI:`IUSC_B_MAP_LO] == 2'(gi));
    end
  endgenerate

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  chk_cfg_ack_lat: assert property (acc |=> o_cfg_ack ##1 (o_cfg_ack == $past(acc)))
    else $error("config access not acknowledged in one cycle");
  chk_reg_readback: assert property ((i_cfg_wr && i_cfg_idx == `IUSC_IDX_IDE_IRQ1)
    ##1 (i_cfg_rd && !i_cfg_wr && i_cfg_idx == `IUSC_IDX_IDE_IRQ1)
    |=> o_cfg_rdata == ($past(i_cfg_wdata, 2) & `IUSC_MSK_IDE_IRQ1))
    else $error("routing register read-back differs from write");
  chk_rsvd_zero: assert property ((i_cfg_rd && !i_cfg_wr && i_cfg_idx == `IUSC_IDX_SA_USB_CTL)
    |=> o_cfg_rdata[2:1] == 2'b00)
    else $error("reserved bits read non-zero");
  chk_route_off: assert property (s_q.route[`IUSC_B_ROUTE_DIS] |-> o_ide_irq1_route == 16'h0000)
    else $error("interrupt routed while routing disabled");
  chk_route_irq14: assert property ((s_q.route == 8'h0E) && i_ide_irq1
    |-> o_ide_irq1_route == 16'h4000)
    else $error("code 1110 does not reach IRQ14");
  chk_route_rsvd: assert property ((s_q.route[3:0] == 4'hD) |-> !o_route_valid)
    else $error("reserved routing code marked valid");
  chk_arb_primary: assert property (!s_q.ctl[`IUSC_B_ARB_SEC] && i_usb_req
    |-> o_primary_bus_request && !o_secondary_bus_request)
    else $error("USB request left the primary pair");
  chk_arb_second: assert property (use_sec && i_usb_req && !i_oth_req
    |-> o_secondary_bus_request && !o_primary_bus_request)
    else $error("USB request not on the secondary pair");
  chk_arb_strap: assert property (s_q.strap_int |-> !o_secondary_bus_request)
    else $error("protocol bit acted with internal arbiter strapped");
  chk_irq8_mask: assert property (flush_mode[0] |-> !o_irq8_pic)
    else $error("IRQ8 reached interrupt controller while masked");
  chk_irq8_pass: assert property ((flush_mode == `IUSC_FLUSH_PIN) |-> o_irq8_pic == i_irq8)
    else $error("IRQ8 blocked in normal flush mode");
  chk_pin_float: assert property ((flush_mode == `IUSC_FLUSH_AUTO) |-> !o_flush_handshake_signal_oe)
    else $error("handshake pin driven in automatic mode");
  chk_ide_decode: assert property (!o_ide_full_decode |-> o_ide_addr_ok)
    else $error("high address bits used in 16-bit decode");
  chk_rom_size: assert property ((i_mem_addr[31:19] == 13'h1FFE) |-> o_rom_hit == o_rom_1mb)
    else $error("ROM decode size wrong");
  chk_usb_gate: assert property (i_usb_irq1 && i_usb_irq12 && i_usb_smi && i_usb_a20
    |-> {o_usb_irq1, o_usb_irq12, o_fast_addr20_gate, o_system_mgmt_interrupt}
        == s_q.usb1[4:1])
    else $error("USB enable gating wrong");
  chk_usb_en_write: assert property ((i_cfg_wr && i_cfg_idx == `IUSC_IDX_SA_USB_CTL)
    |=> o_usb_enable == $past(i_cfg_wdata[0]))
    else $error("USB interface enable not written");
  chk_test_write: assert property ((i_cfg_wr && i_cfg_idx == `IUSC_IDX_USB_CTL1)
    |=> {o_usb_test_sel, o_usb_test_en} == $past(i_cfg_wdata[7:5]))
    else $error("test mode fields not written");
  chk_int_map: assert property (i_usb_int |-> $onehot(o_usb_pci_int))
    else $error("USB interrupt not on exactly one PCI line");

  cov_write_route: cover property (i_cfg_wr && i_cfg_idx == `IUSC_IDX_IDE_IRQ1 ##1 o_cfg_ack);
  cov_sec_grant:   cover property (use_sec && o_secondary_bus_request ##[1:4] o_usb_gnt);
  cov_auto_irq8:   cover property ((flush_mode == `IUSC_FLUSH_AUTO_IRQ8) && i_irq8);
  cov_route_hit:   cover property (o_route_valid && i_ide_irq1);

endmodule

// File: test/iusc_fhs_partner.sv
`timescale 1ns/10ps

module iusc_fhs_partner (
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_en,
  input  wire logic [3:0] i_delay,
  input  wire logic       i_pin,
  output logic            o_oe,
  output logic            o_out
);
  logic       busy_q;
  logic [3:0] cnt_q;

  // Answers a request pulse on the pin after i_delay+1 idle cycles, drives 1 for one cycle
  // Only enabled in pin handshake modes; in the irq8 drive mode it would fight the device
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      busy_q <= 1'b0;
      cnt_q  <= 4'h0;
      o_oe   <= 1'b0;
      o_out  <= 1'b0;
    end else begin
      o_oe  <= 1'b0;
      o_out <= 1'b0;
      if (busy_q) begin
        if (cnt_q == 4'h0) begin
          o_oe   <= 1'b1;
          o_out  <= 1'b1;
          busy_q <= 1'b0;
        end else begin
          cnt_q <= cnt_q - 4'h1;
        end
      end else if (i_en && i_pin && !o_oe) begin
        busy_q <= 1'b1;
        cnt_q  <= i_delay;
      end
    end
  end
endmodule

// File: test/iusc_top_tb.sv
`timescale 1ns/10ps

module iusc_top_tb;
  logic i_clk = 0, i_nrst = 0, i_cfg_wr = 0, i_cfg_rd = 0, i_ide_irq1 = 0, i_int_arb_strap = 0;
  logic i_usb_req = 0, i_oth_req = 0, i_pgnt = 0, i_sgnt = 0, i_flush_req = 0, i_irq8 = 0;
  logic i_usb_irq1 = 0, i_usb_irq12 = 0, i_usb_smi = 0, i_usb_a20 = 0, i_usb_int = 0;
  logic [7:0]  i_cfg_idx = 8'h00, i_cfg_wdata = 8'h00, o_cfg_rdata, rd;
  logic [31:0] i_io_addr = 32'h0, i_mem_addr = 32'h0;
  logic [15:0] o_ide_irq1_route;
  logic [1:0]  o_usb_test_sel;
  logic [3:0]  o_usb_pci_int, p_dly = 4'h0;
  logic o_cfg_ack, o_cfg_hit, o_route_valid, o_primary_bus_request, o_secondary_bus_request;
  logic o_usb_gnt, o_oth_gnt, o_flush_handshake_signal_out, o_flush_handshake_signal_oe;
  logic o_flush_ack, o_irq8_pic, o_ide_addr_ok, o_ide_full_decode, o_rom_hit, o_rom_1mb;
  logic o_usb_enable, o_usb_test_en, o_usb_irq1, o_usb_irq12, o_fast_addr20_gate;
  logic o_system_mgmt_interrupt, o_usb_smiact_en, o_usb_pwren_en;
  logic p_en = 0, p_oe, p_out, last_drv = 1;
  wire  i_flush_handshake_signal_in;
  int   n_errors = 0, checks = 0;

  always #25 i_clk = ~i_clk;

  // Undriven pin shows the inverse of the last driven level, never a stale copy of it
  assign i_flush_handshake_signal_in = o_flush_handshake_signal_oe ? o_flush_handshake_signal_out :
                                       p_oe ? p_out : ~last_drv;
  always @(posedge i_clk) if (o_flush_handshake_signal_oe | p_oe) last_drv <= i_flush_handshake_signal_in;

  iusc_top i_dut (.i_clk, .i_nrst, .i_cfg_idx, .i_cfg_wr, .i_cfg_rd, .i_cfg_wdata, .o_cfg_rdata,
    .o_cfg_ack, .o_cfg_hit, .i_ide_irq1, .o_ide_irq1_route, .o_route_valid, .i_int_arb_strap,
    .i_usb_req, .i_oth_req, .i_pgnt, .i_sgnt, .o_primary_bus_request, .o_secondary_bus_request,
    .o_usb_gnt, .o_oth_gnt, .i_flush_req, .i_irq8, .i_flush_handshake_signal_in,
    .o_flush_handshake_signal_out, .o_flush_handshake_signal_oe, .o_flush_ack, .o_irq8_pic,
    .i_io_addr, .o_ide_addr_ok, .o_ide_full_decode, .i_mem_addr, .o_rom_hit, .o_rom_1mb,
    .o_usb_enable, .o_usb_test_sel, .o_usb_test_en, .i_usb_irq1, .i_usb_irq12, .i_usb_smi,
    .i_usb_a20, .i_usb_int, .o_usb_irq1, .o_usb_irq12, .o_fast_addr20_gate,
    .o_system_mgmt_interrupt, .o_usb_smiact_en, .o_usb_pwren_en, .o_usb_pci_int);

  iusc_fhs_partner i_far (.i_clk, .i_nrst, .i_en(p_en), .i_delay(p_dly),
    .i_pin(i_flush_handshake_signal_in), .o_oe(p_oe), .o_out(p_out));

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cfg(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge i_clk);
    i_cfg_wr    <= wr;
    i_cfg_rd    <= !wr;
    i_cfg_idx   <= idx;
    i_cfg_wdata <= d;
    @(posedge i_clk);
    i_cfg_wr <= 1'b0;
    i_cfg_rd <= 1'b0;
    @(negedge i_clk);
    chk("cfg_ack", 16'h1, o_cfg_ack);
    rd = o_cfg_rdata;
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    cfg(1'b0, idx, 8'h00);
    chk("cfg_rdata", exp, rd);
  endtask

  task automatic do_reset(input logic strap);
    @(posedge i_clk);
    i_nrst          <= 1'b0;
    i_int_arb_strap <= strap;
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
  endtask

  task automatic t_regs;
    logic [7:0] idx [4] = '{8'h4C, 8'h4D, 8'h4E, 8'h4F};
    logic [7:0] msk [4] = '{8'h8F, 8'hF9, 8'hFE, 8'hF0};
    for (int k = 0; k < 4; k++) rd_chk(idx[k], 8'h00);
    rd_chk(8'h4B, 8'h00);
    chk("cfg_hit", 16'h0, o_cfg_hit);
    for (int k = 0; k < 4; k++) begin
      cfg(1'b1, idx[k], 8'hFF);
      rd_chk(idx[k], msk[k]);
      chk("cfg_hit", 16'h1, o_cfg_hit);
    end
    chk("usb_en", 16'h1, o_usb_enable);
    chk("rom_1mb", 16'h1, o_rom_1mb);
    chk("full_dec", 16'h1, o_ide_full_decode);
    chk("test_sel", 16'h3, o_usb_test_sel);
    chk("test_en", 16'h1, o_usb_test_en);
    chk("smiact", 16'h1, o_usb_smiact_en);
    chk("pwren", 16'h1, o_usb_pwren_en);
    for (int k = 0; k < 4; k++) cfg(1'b1, idx[k], 8'h00);
    chk("usb_en", 16'h0, o_usb_enable);
    $display("test regs done");
  endtask

  task automatic t_route;
    logic [15:0] exp;
    @(posedge i_clk);
    i_ide_irq1 <= 1'b1;
    for (int c = 0; c < 16; c++) begin
      cfg(1'b1, 8'h4C, 8'(c));
      exp = (c inside {0, 1, 2, 8, 13}) ? 16'h0 : 16'h1 << c;
      chk("route", exp, o_ide_irq1_route);
      chk("route_ok", 16'(exp != 0), o_route_valid);
    end
    cfg(1'b1, 8'h4C, 8'h85);
    chk("route_dis", 16'h0, o_ide_irq1_route);
    chk("route_ok", 16'h0, o_route_valid);
    // Write then read back to back, no idle cycle between them
    @(posedge i_clk);
    {i_cfg_wr, i_cfg_idx, i_cfg_wdata} <= {1'b1, 8'h4C, 8'h7E};
    @(posedge i_clk);
    {i_cfg_wr, i_cfg_rd} <= 2'b01;
    @(posedge i_clk);
    i_cfg_rd <= 1'b0;
    @(negedge i_clk);
    chk("b2b_rdata", 16'h0E, o_cfg_rdata);
    $display("test route done");
  endtask

  task automatic t_arb(input logic strap);
    @(posedge i_clk);
    i_usb_req <= 1'b1;
    i_sgnt    <= 1'b1;
    cfg(1'b1, 8'h4D, 8'h80);
    chk("sreq", 16'(!strap), o_secondary_bus_request);
    chk("preq", 16'(strap), o_primary_bus_request);
    chk("usb_gnt", 16'(!strap), o_usb_gnt);
    cfg(1'b1, 8'h4D, 8'h00);
    chk("sreq", 16'h0, o_secondary_bus_request);
    chk("preq", 16'h1, o_primary_bus_request);
    @(posedge i_clk);
    i_oth_req <= 1'b1;
    i_pgnt    <= 1'b1;
    @(negedge i_clk);
    chk("gnt_pair", 16'h1, {o_usb_gnt, o_oth_gnt});
    @(posedge i_clk);
    i_oth_req <= 1'b0;
    @(negedge i_clk);
    chk("gnt_pair", 16'h2, {o_usb_gnt, o_oth_gnt});
    @(posedge i_clk);
    i_usb_req <= 1'b0;
    i_pgnt    <= 1'b0;
    $display("test arbitration done");
  endtask

  task automatic t_flush(input logic [1:0] mode, input logic [3:0] dly);
    int n;
    @(posedge i_clk);
    p_en   <= !mode[1];
    p_dly  <= dly;
    i_irq8 <= 1'b1;
    cfg(1'b1, 8'h4D, {1'b0, mode, 5'h00});
    chk("irq8_pic", 16'(!mode[0]), o_irq8_pic);
    chk("pin_oe", 16'(mode == 2'b11), o_flush_handshake_signal_oe);
    @(posedge i_clk);
    i_flush_req <= 1'b1;
    @(posedge i_clk);
    @(negedge i_clk);
    if (mode[1]) begin
      chk("flush_ack", 16'h1, o_flush_ack);
      chk("pin_oe", 16'(mode[0]), o_flush_handshake_signal_oe);
    end else begin
      chk("pin_drv", 16'h3, {o_flush_handshake_signal_oe, o_flush_handshake_signal_out});
      n = 0;
      while (!o_flush_ack) begin
        @(negedge i_clk);
        if (++n > 30) begin
          n_errors++;
          close_out();
        end
      end
      chk("ack_lat", 16'(dly + 3), 16'(n));
    end
    @(posedge i_clk);
    i_flush_req <= 1'b0;
    repeat (3) @(posedge i_clk);
    $display("test flush mode %0d done", mode);
  endtask

  task automatic t_irq8_pin;
    for (int v = 0; v < 2; v++) begin
      @(posedge i_clk);
      i_irq8 <= v[0];
      @(negedge i_clk);
      chk("pin_irq8", {14'h0, 1'b1, v[0]},
          {o_flush_handshake_signal_oe, o_flush_handshake_signal_out});
    end
    $display("test irq8 pin done");
  endtask

  task automatic t_usb;
    logic [3:0] o;
    @(posedge i_clk);
    {i_usb_irq1, i_usb_irq12, i_usb_a20, i_usb_smi, i_usb_int} <= 5'h1F;
    for (int b = 1; b < 5; b++) begin
      cfg(1'b1, 8'h4E, 8'h01 << b);
      o = {o_usb_irq1, o_usb_irq12, o_fast_addr20_gate, o_system_mgmt_interrupt};
      chk("usb_irq_en", 16'h1 << (b - 1), o);
    end
    for (int c = 0; c < 4; c++) begin
      cfg(1'b1, 8'h4F, 8'(c << 4));
      chk("pci_int", 16'h1 << c, o_usb_pci_int);
    end
    $display("test usb done");
  endtask

  task automatic t_decode;
    for (int f = 0; f < 2; f++) begin
      cfg(1'b1, 8'h4D, f[0] ? 8'h18 : 8'h00);
      @(posedge i_clk);
      i_io_addr  <= 32'h0001_01F0;
      i_mem_addr <= 32'hFFF0_0000;
      @(negedge i_clk);
      chk("ide_ok", 16'(!f[0]), o_ide_addr_ok);
      chk("rom_low", 16'(f[0]), o_rom_hit);
      @(posedge i_clk);
      i_mem_addr <= 32'hFFF8_0000;
      @(negedge i_clk);
      chk("rom_top", 16'h1, o_rom_hit);
    end
    $display("test decode done");
  endtask

  initial begin
    do_reset(1'b0);
    t_regs();
    t_route();
    t_arb(1'b0);
    t_flush(2'b00, 4'h0);
    t_flush(2'b01, 4'h4);
    t_flush(2'b10, 4'h0);
    t_flush(2'b11, 4'h0);
    t_irq8_pin();
    t_usb();
    t_decode();
    do_reset(1'b1);
    t_arb(1'b1);
    close_out();
  end
endmodule
